// ### hdl/wiper_ctrl.sv
`timescale 1ns/1ns
// Summary of operation
// - Saved positions recalled and interfaces ready within 2 ms after supply rises.
// - Load instruction updates the wiper between 5 us and 20 us later.
// - Nonvolatile write is self-timed from STOP or store edge, within 10 ms.
// - Tap switch selects in each potentiometer are strictly one-hot.
// - Each 8-bit wiper position decodes to one of 256 taps.
// - Zero selects the low-end tap, all ones the high-end tap.
// - Each wiper has its own volatile position register, host-writable.
// - Four saved registers per wiper, loadable into it, all readable and writable.
// - While selected, each SCL fall steps the chosen wiper up or down, saturating at either end.
// - The two select inputs pick potentiometer 0 to 3.
// - Deselect with SCL and write-protect high stores into the default slot.
// - At power-up each default saved slot is copied into its wiper.
module wiper_ctrl #(
  parameter int NV_WRITE_CYC = wiper_pkg::NV_WRITE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic cs_n,
  input wire logic updown,
  input wire logic pot_select_lo,
  input wire logic pot_select_hi,
  input wire logic wp_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_load,
  input wire logic nv_commit,
  input wire logic [1:0] reg_pot,
  input wire logic [2:0] reg_slot,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic ready,
  output logic nv_busy,
  output logic [31:0] wiper_position,
  output logic [1023:0] tap_sel
);

  // Pin synchronisers; first stage feeds only the second
  logic scl_s1, scl_s2, scl_d;
  logic cs_s1, cs_s2, cs_d;
  logic dir_s1, dir_s2;
  logic wp_s1, wp_s2;
  logic [1:0] sel_s1, sel_s2;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
      dir_s1 <= 1'b0;
      dir_s2 <= 1'b0;
      wp_s1 <= 1'b0;
      wp_s2 <= 1'b0;
      sel_s1 <= 2'h0;
      sel_s2 <= 2'h0;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      dir_s1 <= updown;
      dir_s2 <= dir_s1;
      wp_s1 <= wp_n;
      wp_s2 <= wp_s1;
      sel_s1 <= {pot_select_hi, pot_select_lo};
      sel_s2 <= sel_s1;
    end
  end

  // Edges seen on synchronised levels only
  logic scl_fall, cs_rise;
  assign scl_fall = scl_d & ~scl_s2;
  assign cs_rise = ~cs_d & cs_s2;

  // Core state
  wiper_pkg::phase_e phase, next_phase;
  logic [7:0] wiper [wiper_pkg::POT_COUNT];
  logic [7:0] next_wiper [wiper_pkg::POT_COUNT];
  logic [7:0] saved [wiper_pkg::POT_COUNT][wiper_pkg::SLOT_COUNT];
  logic [7:0] next_saved [wiper_pkg::POT_COUNT][wiper_pkg::SLOT_COUNT];
  logic load_pend, next_load_pend;
  logic [1:0] load_pot, next_load_pot, load_slot, next_load_slot;
  logic [wiper_pkg::LOAD_CNT_W-1:0] load_cnt, next_load_cnt;
  logic next_nv_busy;
  logic [wiper_pkg::NV_CNT_W-1:0] nv_cnt, next_nv_cnt;
  logic [1:0] nv_pot, next_nv_pot, nv_slot, next_nv_slot;
  logic [7:0] nv_data, next_nv_data;
  logic stage_valid, next_stage_valid;
  logic [1:0] stage_pot, next_stage_pot, stage_slot, next_stage_slot;
  logic [7:0] stage_data, next_stage_data;
  logic [7:0] next_rdata;

  // Next-state logic; later assignments win over earlier ones
  always_comb begin
    next_phase = phase;
    next_wiper = wiper;
    next_saved = saved;
    next_load_pend = load_pend;
    next_load_pot = load_pot;
    next_load_slot = load_slot;
    next_load_cnt = load_cnt;
    next_nv_busy = nv_busy;
    next_nv_cnt = nv_cnt;
    next_nv_pot = nv_pot;
    next_nv_slot = nv_slot;
    next_nv_data = nv_data;
    next_stage_valid = stage_valid;
    next_stage_pot = stage_pot;
    next_stage_slot = stage_slot;
    next_stage_data = stage_data;
    next_rdata = reg_rdata;
    unique case (phase)
      wiper_pkg::PH_RECALL: begin
        // One cycle of recall keeps readiness far inside the power-up limit
        for (int p = 0; p < wiper_pkg::POT_COUNT; p++) begin
          next_wiper[p] = saved[p][wiper_pkg::DEFAULT_SLOT];
        end
        next_phase = wiper_pkg::PH_RUN;
      end
      wiper_pkg::PH_RUN: begin
        // Delayed load lands at the least response time
        if (load_pend) begin
          if (load_cnt == wiper_pkg::LOAD_CNT_W'(wiper_pkg::LOAD_CYC - 1)) begin
            next_wiper[load_pot] = saved[load_pot][load_slot];
            next_load_pend = 1'b0;
          end else begin
            next_load_cnt = load_cnt + 1'b1;
          end
        end
        // Self-timed write commits at the end of its cycle
        if (nv_busy) begin
          if (nv_cnt == wiper_pkg::NV_CNT_W'(NV_WRITE_CYC - 1)) begin
            next_saved[nv_pot][nv_slot] = nv_data;
            next_nv_busy = 1'b0;
          end else begin
            next_nv_cnt = nv_cnt + 1'b1;
          end
        end
        // Up/down stepping with saturation
        if (!cs_s2 && scl_fall) begin
          if (dir_s2) begin
            if (wiper[sel_s2] != wiper_pkg::POS_MAX) begin
              next_wiper[sel_s2] = wiper[sel_s2] + 1'b1;
            end
          end else if (wiper[sel_s2] != wiper_pkg::POS_MIN) begin
            next_wiper[sel_s2] = wiper[sel_s2] - 1'b1;
          end
        end
        // Store on deselect only with SCL and write-protect high
        if (cs_rise && scl_s2 && wp_s2 && !nv_busy) begin
          next_nv_busy = 1'b1;
          next_nv_cnt = '0;
          next_nv_pot = sel_s2;
          next_nv_slot = wiper_pkg::DEFAULT_SLOT;
          next_nv_data = wiper[sel_s2];
        end
        // Host port, ignored while the up/down interface holds the device
        if (cs_s2) begin
          if (reg_wr) begin
            if (reg_slot == wiper_pkg::SLOT_WIPER) begin
              next_wiper[reg_pot] = reg_wdata;
            end else if (!nv_busy) begin
              // Saved writes wait for the closing STOP
              next_stage_valid = 1'b1;
              next_stage_pot = reg_pot;
              next_stage_slot = reg_slot[1:0];
              next_stage_data = reg_wdata;
            end
          end
          if (reg_load && reg_slot != wiper_pkg::SLOT_WIPER) begin
            next_load_pend = 1'b1;
            next_load_cnt = '0;
            next_load_pot = reg_pot;
            next_load_slot = reg_slot[1:0];
          end
          if (nv_commit && stage_valid && !nv_busy) begin
            next_stage_valid = 1'b0;
            next_nv_busy = 1'b1;
            next_nv_cnt = '0;
            next_nv_pot = stage_pot;
            next_nv_slot = stage_slot;
            next_nv_data = stage_data;
          end
          if (reg_rd) begin
            if (reg_slot == wiper_pkg::SLOT_WIPER) begin
              next_rdata = wiper[reg_pot];
            end else begin
              next_rdata = saved[reg_pot][reg_slot[1:0]];
            end
          end
        end
      end
    endcase
  end

  // Core registers; saved slots take a fixed value since no real NV cell exists here
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase <= wiper_pkg::PH_RECALL;
      for (int p = 0; p < wiper_pkg::POT_COUNT; p++) begin
        wiper[p] <= wiper_pkg::WIPER_RESET;
        for (int s = 0; s < wiper_pkg::SLOT_COUNT; s++) begin
          saved[p][s] <= wiper_pkg::SAVED_RESET;
        end
      end
      load_pend <= 1'b0;
      load_pot <= 2'h0;
      load_slot <= 2'h0;
      load_cnt <= '0;
      nv_busy <= 1'b0;
      nv_cnt <= '0;
      nv_pot <= 2'h0;
      nv_slot <= 2'h0;
      nv_data <= 8'h00;
      stage_valid <= 1'b0;
      stage_pot <= 2'h0;
      stage_slot <= 2'h0;
      stage_data <= 8'h00;
      reg_rdata <= 8'h00;
    end else begin
      phase <= next_phase;
      wiper <= next_wiper;
      saved <= next_saved;
      load_pend <= next_load_pend;
      load_pot <= next_load_pot;
      load_slot <= next_load_slot;
      load_cnt <= next_load_cnt;
      nv_busy <= next_nv_busy;
      nv_cnt <= next_nv_cnt;
      nv_pot <= next_nv_pot;
      nv_slot <= next_nv_slot;
      nv_data <= next_nv_data;
      stage_valid <= next_stage_valid;
      stage_pot <= next_stage_pot;
      stage_slot <= next_stage_slot;
      stage_data <= next_stage_data;
      reg_rdata <= next_rdata;
    end
  end

  assign ready = (phase == wiper_pkg::PH_RUN);

  // Per-pot tap decode, registered so the one-hot word never glitches
  generate
    for (genvar g = 0; g < wiper_pkg::POT_COUNT; g++) begin : g_pot
      logic [255:0] next_tap;
      assign next_tap = wiper_pkg::TAP_ONE << next_wiper[g];
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          tap_sel[g*wiper_pkg::TAP_COUNT +: wiper_pkg::TAP_COUNT] <= wiper_pkg::TAP_ONE;
          wiper_position[g*wiper_pkg::POS_W +: wiper_pkg::POS_W] <= wiper_pkg::WIPER_RESET;
        end else begin
          tap_sel[g*wiper_pkg::TAP_COUNT +: wiper_pkg::TAP_COUNT] <= next_tap;
          wiper_position[g*wiper_pkg::POS_W +: wiper_pkg::POS_W] <= next_wiper[g];
        end
      end
    end
  endgenerate

endmodule // wiper_ctrl

// ### hdl/wiper_pkg.sv
package wiper_pkg;
  // System clock rate
  localparam int CLK_MHZ = 50;
  // Wiper response window after a load instruction
  localparam int LOAD_MIN_US = 5;
  localparam int LOAD_MAX_US = 20;
  // Least time rounded up; stays well below the longest time
  localparam int LOAD_CYC = LOAD_MIN_US * CLK_MHZ;
  localparam int LOAD_CNT_W = 9;
  // Self-timed nonvolatile write, typical and longest
  localparam int NV_WRITE_TYP_MS = 5;
  localparam int NV_WRITE_MAX_MS = 10;
  localparam int NV_WRITE_CYC = NV_WRITE_TYP_MS * 1000 * CLK_MHZ;
  localparam int NV_CNT_W = 24;
  // Power-up readiness limit
  localparam int POWERUP_MAX_MS = 2;
  // Geometry
  localparam int POT_COUNT = 4;
  localparam int SLOT_COUNT = 4;
  localparam int POS_W = 8;
  localparam int TAP_COUNT = 256;
  // Slot codes on the host port; codes 0..3 are saved slots
  localparam logic [2:0] SLOT_WIPER = 3'h4;
  localparam logic [1:0] DEFAULT_SLOT = 2'h0;
  // Position limits and reset values
  localparam logic [7:0] POS_MIN = 8'h00;
  localparam logic [7:0] POS_MAX = 8'hff;
  localparam logic [7:0] WIPER_RESET = 8'h00;
  localparam logic [7:0] SAVED_RESET = 8'h00;
  localparam logic [255:0] TAP_ONE = 256'h1;
  // Recall first, then run
  typedef enum logic [1:0] {
    PH_RECALL = 2'b01,
    PH_RUN = 2'b10
  } phase_e;
endpackage

// ### bench/wiper_sva.sv
`timescale 1ns/1ns
// Port watch on the wiper block
module wiper_sva #(
  parameter int NV_WRITE_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic cs_n,
  input wire logic updown,
  input wire logic wp_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_load,
  input wire logic [2:0] reg_slot,
  input wire logic [7:0] reg_rdata,
  input wire logic ready,
  input wire logic nv_busy,
  input wire logic [31:0] wiper_position,
  input wire logic [1023:0] tap_sel
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Each pot closes only the switch its position names
  property p_tap;
    $onehot(tap_sel[255:0]) && $onehot(tap_sel[511:256]) &&
      $onehot(tap_sel[767:512]) && $onehot(tap_sel[1023:768]) &&
      tap_sel[wiper_position[7:0]] && tap_sel[256 + wiper_position[15:8]] &&
      tap_sel[512 + wiper_position[23:16]] && tap_sel[768 + wiper_position[31:24]];
  endproperty
  property p_rdy; !ready |=> ready; endproperty
  property p_busy_len; $rose(nv_busy) |-> nv_busy[*8]; endproperty
  property p_busy_max; $rose(nv_busy) |-> ##[1:NV_WRITE_CYC] !nv_busy; endproperty
  property p_rdata; !reg_rd |=> $stable(reg_rdata); endproperty
  // Too early a load would break the least response time
  property p_load_min;
    reg_load && ready && cs_n && !reg_slot[2] |=> $stable(wiper_position)[*8];
  endproperty
  property p_store; $rose(cs_n) && scl_in && wp_n && ready && !nv_busy |-> ##[2:6] nv_busy;
  endproperty
  property p_sat; wiper_position[15:8] == 8'hff && updown && !reg_wr |=>
    wiper_position[15:8] != 8'h00; endproperty
  a_tap: assert property (p_tap) else $error("tap select off");
  a_rdy: assert property (p_rdy) else $error("ready late");
  a_busy_len: assert property (p_busy_len) else $error("write short");
  a_busy_max: assert property (p_busy_max) else $error("write long");
  a_rdata: assert property (p_rdata) else $error("read data moved");
  a_load_min: assert property (p_load_min) else $error("load early");
  a_store: assert property (p_store) else $error("no store");
  a_sat: assert property (p_sat) else $error("wiper wrapped");
  c_busy: cover property ($rose(nv_busy));
  c_step: cover property (!cs_n && $changed(wiper_position));
  c_top: cover property (wiper_position[15:8] == 8'hff && updown);
endmodule // wiper_sva

// ### bench/wiper_host.sv
`timescale 1ns/1ns
// Host on the up/down link; SCL rests high between frames
module wiper_host #(
  parameter int STORE_GAP = 40
) (
  input wire logic clk_sys,
  output logic scl_in,
  output logic cs_n,
  output logic updown,
  output logic pot_select_lo,
  output logic pot_select_hi,
  output logic wp_n
);
  // Idle levels from time zero; device select high through power-up
  initial begin
    scl_in = 1'b1;
    cs_n = 1'b1;
    updown = 1'b0;
    pot_select_lo = 1'b0;
    pot_select_hi = 1'b0;
    wp_n = 1'b1;
  end
  // Land just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  // Select, n falls, deselect; SCL high at deselect asks a store
  task automatic move(input logic [1:0] pot, input logic up, input int n, input logic st,
      input logic wp);
    {pot_select_hi, pot_select_lo} = pot;
    updown = up;
    wp_n = wp;
    tick(50);
    cs_n = 1'b0;
    tick(50);
    repeat (n) begin
      scl_in = 1'b1;
      tick(4);
      scl_in = 1'b0;
      tick(4);
    end
    scl_in = st;
    tick(50);
    cs_n = 1'b1;
    // Store gap scaled with the shortened write
    tick(st ? STORE_GAP : 50);
    scl_in = 1'b1;
  endtask
endmodule // wiper_host

// ### bench/wiper_ctrl_tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the wiper block
module wiper_ctrl_tb_top;
  localparam int NV = 20;
  logic clk_sys, rst_n, reg_wr, reg_rd, reg_load, nv_commit, ready, nv_busy;
  logic scl_in, cs_n, updown, pot_select_lo, pot_select_hi, wp_n;
  logic [1:0] reg_pot;
  logic [2:0] reg_slot;
  logic [7:0] reg_wdata, reg_rdata;
  logic [31:0] wiper_position;
  logic [1023:0] tap_sel;
  int err_count, checks;
  typedef struct {logic [1:0] pot; logic [2:0] slot; logic [7:0] data;} row_s;
  row_s rows[6] = '{'{2'h0, 3'h4, 8'h00}, '{2'h1, 3'h4, 8'hff}, '{2'h2, 3'h4, 8'h5a},
    '{2'h3, 3'h0, 8'h3c}, '{2'h2, 3'h3, 8'hc3}, '{2'h1, 3'h1, 8'h81}};
  wiper_ctrl #(.NV_WRITE_CYC(NV)) wiper_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .scl_in(scl_in), .cs_n(cs_n), .updown(updown), .pot_select_lo(pot_select_lo),
    .pot_select_hi(pot_select_hi), .wp_n(wp_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_load(reg_load), .nv_commit(nv_commit), .reg_pot(reg_pot), .reg_slot(reg_slot),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ready(ready), .nv_busy(nv_busy),
    .wiper_position(wiper_position), .tap_sel(tap_sel));
  wiper_host #(.STORE_GAP(2 * NV)) wiper_host_i (.clk_sys(clk_sys), .scl_in(scl_in),
    .cs_n(cs_n), .updown(updown), .pot_select_lo(pot_select_lo),
    .pot_select_hi(pot_select_hi), .wp_n(wp_n));
  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("err_count %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Pulse {wr, rd, load, commit} for one cycle, then a quiet cycle
  task automatic op(input logic [3:0] k, input logic [1:0] p, input logic [2:0] s,
      input logic [7:0] d);
    {reg_wr, reg_rd, reg_load, nv_commit} = k;
    reg_pot = p;
    reg_slot = s;
    reg_wdata = d;
    wiper_host_i.tick(1);
    {reg_wr, reg_rd, reg_load, nv_commit} = 4'h0;
    wiper_host_i.tick(1);
  endtask
  // Bounded wait for the self-timed write
  task automatic wait_idle;
    int n = 0;
    wiper_host_i.tick(3);
    while (nv_busy !== 1'b0) begin
      wiper_host_i.tick(1);
      n++;
      if (n > 4 * NV) begin
        err_count++;
        stop_test();
      end
    end
  endtask
  initial begin
    rst_n = 1'b0;
    err_count = 0;
    checks = 0;
    op(4'h0, 2'h0, 3'h0, 8'h00);
    repeat (20) @(posedge clk_sys);
    #2;
    check({ready, nv_busy, tap_sel[0], tap_sel[256], tap_sel[512], tap_sel[768]}, 6'h0f);
    check(wiper_position, 32'h0);
    rst_n = 1'b1;
    wiper_host_i.tick(3);
    check(ready, 1'b1);
    // Write every kind of place, commit saved ones, read back
    foreach (rows[i]) begin
      op(4'h8, rows[i].pot, rows[i].slot, rows[i].data);
      if (!rows[i].slot[2]) begin
        op(4'h1, 2'h0, 3'h0, 8'h00);
        wait_idle();
      end
      op(4'h4, rows[i].pot, rows[i].slot, 8'h00);
      check(reg_rdata, rows[i].data);
      if (rows[i].slot[2]) begin
        check({wiper_position[rows[i].pot*8+:8], tap_sel[rows[i].pot*256+rows[i].data]},
          {rows[i].data, 1'b1});
      end
    end
    // Load lands after 5 us, well inside 20 us
    op(4'h2, 2'h3, 3'h0, 8'h00);
    wiper_host_i.tick(240);
    check(wiper_position[31:24], 8'h00);
    wiper_host_i.tick(20);
    check(wiper_position[31:24], 8'h3c);
    // Two steps on each pot, odd pots up; ends pin at the limits
    for (int p = 0; p < 4; p++) begin
      wiper_host_i.move(p[1:0], p[0], 2, 1'b0, 1'b1);
    end
    check(wiper_position, 32'h3e58ff00);
    // Store, then refused by write protect and by SCL low
    wiper_host_i.move(2'h2, 1'b1, 1, 1'b1, 1'b1);
    wait_idle();
    wiper_host_i.move(2'h2, 1'b1, 1, 1'b1, 1'b0);
    wiper_host_i.move(2'h2, 1'b1, 1, 1'b0, 1'b1);
    op(4'h4, 2'h2, 3'h0, 8'h00);
    check({reg_rdata, wiper_position[23:16]}, 16'h595b);
    // A second write during the busy window is dropped
    op(4'h8, 2'h0, 3'h1, 8'ha5);
    op(4'h1, 2'h0, 3'h0, 8'h00);
    op(4'h8, 2'h0, 3'h1, 8'h11);
    op(4'h1, 2'h0, 3'h0, 8'h00);
    check(nv_busy, 1'b1);
    wait_idle();
    op(4'h4, 2'h0, 3'h1, 8'h00);
    check(reg_rdata, 8'ha5);
    // Mid-run reset drops readiness and clears every place
    rst_n = 1'b0;
    wiper_host_i.tick(2);
    check({ready, nv_busy, reg_rdata}, 10'h0);
    check(wiper_position, 32'h0);
    rst_n = 1'b1;
    wiper_host_i.tick(3);
    check(ready, 1'b1);
    check(wiper_position, 32'h0);
    stop_test();
  end
endmodule // wiper_ctrl_tb_top
bind wiper_ctrl wiper_sva #(.NV_WRITE_CYC(NV_WRITE_CYC)) wiper_sva_i (.clk_sys(clk_sys),
  .rst_n(rst_n), .scl_in(scl_in), .cs_n(cs_n), .updown(updown), .wp_n(wp_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_load(reg_load), .reg_slot(reg_slot),
  .reg_rdata(reg_rdata), .ready(ready), .nv_busy(nv_busy),
  .wiper_position(wiper_position), .tap_sel(tap_sel));
